/* design/ld_cfg.svh */
// Purpose: Offsets, field positions, masks and reset values of the load unit.
// Assumes: Included by every design file that needs a number.
// Notes: Definitions only.
`ifndef LD_CFG_SVH
`define LD_CFG_SVH
`define LD_BIT_I 25
`define LD_BIT_P 24
`define LD_BIT_U 23
`define LD_BIT_SB 22
`define LD_BIT_W 21
`define LD_PC_IDX 4'hf
`define LD_PC_MASK 32'h03fffffc
`define LD_PSR_MASK 32'hfc000003
`define LD_PC_AHEAD 32'h00000008
`define LD_PC_RESTORE_ADJ 32'h0000000c
`define LD_WORD_BYTES 32'h00000004
`define LD_MODE_USER 2'h0
`define LD_MODE_SVC 2'h3
`define LD_REG_CTRL 4'h0
`define LD_REG_STATUS 4'h1
`define LD_REG_COUNT 4'h2
`define LD_CTRL_RST 1'h1
`endif

/* design/ld_pkg.sv */
// Purpose: Types and shared functions of the load unit.
// Assumes: Numbers live in ld_cfg.svh.
// Notes: None.
package ld_pkg;
  typedef enum logic [2:0] {st_idle, st_rd_base, st_rd_off, st_mem, st_wb}
    ld_state_t;

  typedef struct packed {
    ld_state_t st;
    logic [31:0] ins;
    logic [31:0] pc;
    logic [31:0] base;
    logic [31:0] wb_val;
    logic [15:0] list;
    logic enable;
    logic skipped;
    logic [15:0] loads;
    logic busy;
    logic done;
    logic [3:0] rf_raddr;
    logic rf_ren;
    logic [3:0] rf_waddr;
    logic [31:0] rf_wdata;
    logic rf_wen;
    logic rf_user;
    logic psr_wen;
    logic [31:0] psr_wdata;
    logic mem_req;
    logic [31:0] mem_addr;
    logic mem_byte;
    logic mem_trans;
    logic [31:0] reg_rdata;
  } ld_regs_t;

  // Condition field against the N, Z, C, V flags.
  function automatic logic ld_cond_pass(input logic [3:0] c,
                                        input logic [3:0] f);
    logic n;
    logic z;
    logic cy;
    logic v;
    logic r;
    n = f[3];
    z = f[2];
    cy = f[1];
    v = f[0];
    unique case (c[3:1])
      3'h0: r = z;
      3'h1: r = cy;
      3'h2: r = n;
      3'h3: r = v;
      3'h4: r = cy & ~z;
      3'h5: r = (n == v);
      3'h6: r = ~z & (n == v);
      3'h7: r = 1'b1;
    endcase
    if (c[3:1] != 3'h7)
    begin
      r = r ^ c[0];
    end
    else
    begin
      r = ~c[0];
    end
    return r;
  endfunction
endpackage

/* design/ld_aux_if.sv */
// Purpose: Carries list scan and shift signals between the load unit parts.
// Assumes: All combinational.
// Notes: None.
`timescale 1ns/1ps
`default_nettype none
interface ld_aux_if;
  logic [15:0] list;
  logic [3:0] low_idx;
  logic any;
  logic [4:0] count;
  logic [31:0] sh_in;
  logic [1:0] sh_type;
  logic [4:0] sh_amt;
  logic [31:0] sh_out;
  modport core_mp(output list, sh_in, sh_type, sh_amt,
                  input low_idx, any, count, sh_out);
  modport scan_mp(input list, output low_idx, any, count);
  modport shift_mp(input sh_in, sh_type, sh_amt, output sh_out);
endinterface
`default_nettype wire

/* design/ld_list_scan.sv */
// Purpose: Finds the lowest selected register and counts the selection.
// Assumes: Sixteen-entry list.
// Notes: Combinational.
`timescale 1ns/1ps
`default_nettype none
module ld_list_scan import ld_pkg::*; #(
  parameter int NREG = 16
) (
  ld_aux_if.scan_mp aux
);
  if (NREG != 16)
  begin : g_chk
    $error("ld_list_scan serves exactly sixteen registers");
  end

  always_comb
  begin
    aux.low_idx = 4'h0;
    aux.any = 1'b0;
    aux.count = 5'h00;
    for (int i = NREG - 1; i >= 0; i--)
    begin
      if (aux.list[i])
      begin
        aux.low_idx = 4'(i);
        aux.any = 1'b1;
        aux.count = aux.count + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* design/ld_shifter.sv */
// Purpose: Shifts or rotates the offset register value.
// Assumes: Types 0 to 3 are left, logical right, arithmetic right, rotate.
// Notes: A count of zero passes the value unchanged.
`timescale 1ns/1ps
`default_nettype none
module ld_shifter import ld_pkg::*; #(
  parameter int WIDTH = 32
) (
  ld_aux_if.shift_mp aux
);
  if (WIDTH != 32)
  begin : g_chk
    $error("ld_shifter serves 32-bit words only");
  end

  always_comb
  begin
    unique case (aux.sh_type)
      2'h0: aux.sh_out = aux.sh_in << aux.sh_amt;
      2'h1: aux.sh_out = aux.sh_in >> aux.sh_amt;
      2'h2: aux.sh_out = 32'($signed(aux.sh_in) >>> aux.sh_amt);
      2'h3: aux.sh_out = (aux.sh_in >> aux.sh_amt) |
                         (aux.sh_in << (6'h20 - {1'b0, aux.sh_amt}));
    endcase
    if (aux.sh_amt == 5'h00)
    begin
      aux.sh_out = aux.sh_in;
    end
  end
endmodule
`default_nettype wire

/* design/ld_load_unit.sv */
// Purpose: Executes block pop loads and single word or byte loads.
// Assumes: Register file answers a read in the cycle rf_ren stands; memory
//   answers a held mem_req with a one-cycle mem_rvalid.
// Notes: Software reaches control and status over the plain register port.
//
// Contract
// - Block load reads words through the base register into listed registers.
// - Any subset of the sixteen registers may be listed.
// - Base tracks internally; final value written only with write-back bit.
// - Block load keeps the flags unless privileged with the status-load bit set and PC listed.
// - Four directions: increment or decrement, before or after each word.
// - Privileged, status bit, PC listed: load status, use current bank.
// - Privileged, status bit, no PC: user bank; user mode ignores bit.
// - Status restored from the value saved with the PC word.
// - Single load reads a byte or a word as the byte bit selects.
// - Single load base may be any register, PC included.
// - Unsigned 12-bit immediate offset applied pre or post transfer.
// - Offset held as magnitude; up bit chooses add or subtract.
// - Offset may be a register shifted or rotated by 1 to 31.
// - Supervisor post-indexed translate load raises the translate pin.
// - Lowest listed register always takes the lowest address.
// - Loads execute only when the condition field passes.
// - PC as base is flagless and eight bytes ahead.
`include "ld_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ld_load_unit import ld_pkg::*; (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] instr_pc,
  input wire logic [3:0] cond_flags,
  input wire logic [1:0] cpu_mode,
  output logic busy,
  output logic done,
  output logic [3:0] rf_raddr,
  output logic rf_ren,
  input wire logic [31:0] rf_rdata,
  output logic [3:0] rf_waddr,
  output logic [31:0] rf_wdata,
  output logic rf_wen,
  output logic rf_user,
  output logic psr_wen,
  output logic [31:0] psr_wdata,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic mem_byte,
  output logic mem_trans,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  ld_regs_t q;
  ld_regs_t d;
  ld_aux_if aux();

  logic is_ldm;
  logic up;
  logic pre;
  logic sbit;
  logic wbit;
  logic priv;
  logic [3:0] rn;
  logic [3:0] rd;
  logic pc_listed;
  logic [31:0] span;
  logic [31:0] base_now;
  logic [31:0] off;
  logic [31:0] moved;
  logic [7:0] lane;
  logic wb_blocked;

  ld_list_scan u_scan (
    .aux(aux)
  );

  ld_shifter u_shift (
    .aux(aux)
  );

  // ---------------------------------------------------------------
  // Instruction fields
  // ---------------------------------------------------------------
  assign is_ldm = q.ins[27];
  assign up = q.ins[`LD_BIT_U];
  assign pre = q.ins[`LD_BIT_P];
  assign sbit = q.ins[`LD_BIT_SB];
  assign wbit = q.ins[`LD_BIT_W];
  assign rn = q.ins[19:16];
  assign rd = q.ins[15:12];
  assign priv = (cpu_mode != `LD_MODE_USER);
  assign pc_listed = q.ins[15];
  assign aux.list = q.list;
  assign aux.sh_in = rf_rdata;
  assign aux.sh_type = q.ins[6:5];
  assign aux.sh_amt = q.ins[11:7];
  assign span = 32'(aux.count) << 2;
  assign base_now = (rn == `LD_PC_IDX) ?
                    ((q.pc + `LD_PC_AHEAD) & `LD_PC_MASK) : rf_rdata;
  // Register offsets are shifted first; immediates are a 12-bit magnitude.
  assign off = q.ins[`LD_BIT_I] ? aux.sh_out : {20'h00000, q.ins[11:0]};
  assign moved = up ? (q.base + off) : (q.base - off);
  assign lane = mem_rdata[8 * q.mem_addr[1:0] +: 8];
  assign wb_blocked = is_ldm ? q.ins[rn] : (rd == rn);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.rf_ren = 1'b0;
    d.rf_wen = 1'b0;
    d.psr_wen = 1'b0;
    d.reg_rdata = 32'h00000000;
    if (reg_wr && reg_addr == `LD_REG_CTRL)
    begin
      d.enable = reg_wdata[0];
    end
    unique case (q.st)
      st_idle:
      begin
        if (instr_valid && q.enable)
        begin
          d.ins = instr_word;
          d.pc = instr_pc;
          d.list = instr_word[15:0];
          if (ld_cond_pass(instr_word[31:28], cond_flags))
          begin
            d.skipped = 1'b0;
            d.rf_raddr = instr_word[19:16];
            d.rf_ren = 1'b1;
            d.rf_user = 1'b0;
            d.st = st_rd_base;
          end
          else
          begin
            d.skipped = 1'b1;
            d.done = 1'b1;
          end
        end
      end
      st_rd_base:
      begin
        d.base = base_now;
        if (is_ldm)
        begin
          // Every direction walks upward from its lowest address.
          if (up)
          begin
            d.mem_addr = pre ? base_now + `LD_WORD_BYTES : base_now;
            d.wb_val = base_now + span;
          end
          else
          begin
            d.mem_addr = pre ? base_now - span :
                         base_now - span + `LD_WORD_BYTES;
            d.wb_val = base_now - span;
          end
          d.mem_byte = 1'b0;
          d.mem_trans = 1'b0;
          // Status bit in user mode changes nothing.
          d.rf_user = sbit && priv && !pc_listed;
          if (aux.any)
          begin
            d.mem_req = 1'b1;
            d.st = st_mem;
          end
          else
          begin
            d.st = st_wb;
          end
        end
        else
        begin
          d.rf_raddr = q.ins[3:0];
          d.rf_ren = q.ins[`LD_BIT_I];
          d.st = st_rd_off;
        end
      end
      st_rd_off:
      begin
        d.mem_addr = pre ? moved : q.base;
        d.wb_val = moved;
        d.mem_byte = q.ins[`LD_BIT_SB];
        d.mem_trans = !pre && wbit && (cpu_mode == `LD_MODE_SVC);
        d.mem_req = 1'b1;
        d.st = st_mem;
      end
      st_mem:
      begin
        if (mem_rvalid)
        begin
          d.mem_req = 1'b0;
          d.mem_trans = 1'b0;
          d.rf_wen = 1'b1;
          d.loads = q.loads + 16'h0001;
          if (is_ldm)
          begin
            d.rf_waddr = aux.low_idx;
            d.rf_wdata = mem_rdata;
            if (aux.low_idx == `LD_PC_IDX)
            begin
              d.rf_wdata = (mem_rdata - `LD_PC_RESTORE_ADJ) & `LD_PC_MASK;
              if (sbit && priv)
              begin
                d.psr_wen = 1'b1;
                d.psr_wdata = mem_rdata & `LD_PSR_MASK;
              end
            end
            d.list[aux.low_idx] = 1'b0;
            if (aux.count > 5'h01)
            begin
              d.mem_req = 1'b1;
              d.mem_addr = q.mem_addr + `LD_WORD_BYTES;
            end
            else
            begin
              d.st = st_wb;
            end
          end
          else
          begin
            d.rf_waddr = rd;
            if (q.mem_byte)
            begin
              d.rf_wdata = {24'h000000, lane};
            end
            else
            begin
              // Word loads assume an aligned address from software.
              d.rf_wdata = mem_rdata;
            end
            if (rd == `LD_PC_IDX)
            begin
              d.rf_wdata = mem_rdata & `LD_PC_MASK;
            end
            d.st = st_wb;
          end
        end
      end
      st_wb:
      begin
        // A loaded value of the base register beats the write-back.
        d.rf_user = 1'b0;
        d.rf_waddr = rn;
        d.rf_wdata = q.wb_val;
        d.rf_wen = (wbit || (!is_ldm && !pre)) && !wb_blocked;
        d.done = 1'b1;
        d.st = st_idle;
      end
    endcase
    d.busy = (d.st != st_idle);
    if (reg_rd)
    begin
      unique case (reg_addr)
        `LD_REG_CTRL: d.reg_rdata = {31'h00000000, q.enable};
        `LD_REG_STATUS: d.reg_rdata = {29'h00000000, is_ldm, q.skipped,
                                       q.busy};
        `LD_REG_COUNT: d.reg_rdata = {16'h0000, q.loads};
        default: d.reg_rdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.st <= st_idle;
      q.enable <= `LD_CTRL_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign done = q.done;
  assign rf_raddr = q.rf_raddr;
  assign rf_ren = q.rf_ren;
  assign rf_waddr = q.rf_waddr;
  assign rf_wdata = q.rf_wdata;
  assign rf_wen = q.rf_wen;
  assign rf_user = q.rf_user;
  assign psr_wen = q.psr_wen;
  assign psr_wdata = q.psr_wdata;
  assign mem_req = q.mem_req;
  assign mem_addr = q.mem_addr;
  assign mem_byte = q.mem_byte;
  assign mem_trans = q.mem_trans;
  assign reg_rdata = q.reg_rdata;
endmodule
`default_nettype wire

/* bench/ld_mem_model.sv */
// Purpose: Memory controller stand-in answering load requests.
// Assumes: One answer per held request, 1 to 4 cycles after it.
// Notes: Data outside an answer toggles so a stale word never passes.
`timescale 1ns/1ps
`default_nettype none
module ld_mem_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output var logic mem_rvalid,
  output var logic [31:0] mem_rdata
);
  logic [1:0] wait_q;
  initial mem_rdata = 32'h0;
  always @(posedge core_clk)
  begin
    mem_rdata <= ~mem_rdata;
    if (sys_rst || mem_rvalid || !mem_req)
    begin
      mem_rvalid <= 1'b0;
      wait_q <= 2'($urandom % 4);
    end
    else if (wait_q == 2'h0)
    begin
      mem_rvalid <= 1'b1;
      mem_rdata <= {~mem_addr[17:2], mem_addr[17:2]};
    end
    else
      wait_q <= wait_q - 2'h1;
  end
endmodule
`default_nettype wire

/* bench/ld_checker.sv */
// Purpose: Port assertions for the load unit.
// Assumes: Bound to the top module, one clock domain.
// Notes: Covers mark the main scenarios.
`timescale 1ns/1ps
`default_nettype none
module ld_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [1:0] cpu_mode,
  input wire logic busy,
  input wire logic done,
  input wire logic rf_ren,
  input wire logic rf_wen,
  input wire logic rf_user,
  input wire logic [3:0] rf_waddr,
  input wire logic [31:0] rf_wdata,
  input wire logic psr_wen,
  input wire logic [31:0] psr_wdata,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_trans,
  input wire logic mem_rvalid
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  req_hold_a: assert property (
    mem_req && !mem_rvalid |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped or moved early");
  mem_busy_a: assert property (mem_req |-> busy)
    else $error("memory request while idle");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  cond_skip_a: assert property (
    instr_valid && !busy && !done && instr_word[31:28] == 4'hf
    |=> (!rf_ren && !mem_req) [*2])
    else $error("failed condition still ran");
  trans_mode_a: assert property (
    mem_req && mem_trans |-> cpu_mode == 2'h3)
    else $error("translate outside supervisor");
  psr_priv_a: assert property (
    psr_wen |-> cpu_mode != 2'h0 && psr_wdata[25:2] == 24'h0)
    else $error("bad status write");
  user_bank_a: assert property (
    rf_wen && rf_user |-> cpu_mode != 2'h0)
    else $error("user bank write in user mode");
  pc_clean_a: assert property (
    rf_wen && rf_waddr == 4'hf |-> rf_wdata[31:26] == 6'h0
    && rf_wdata[1:0] == 2'h0)
    else $error("pc written with flag bits");
  cover property (psr_wen);
  cover property (mem_req && mem_trans);
  cover property (rf_wen && rf_user);
endmodule
bind ld_load_unit ld_checker ld_checker_i (.core_clk, .sys_rst,
  .instr_valid, .instr_word, .cpu_mode, .busy, .done, .rf_ren, .rf_wen,
  .rf_user, .rf_waddr, .rf_wdata, .psr_wen, .psr_wdata, .mem_req,
  .mem_addr, .mem_trans, .mem_rvalid);
`default_nettype wire

/* bench/testbench.sv */
// Purpose: Self-checking bench for the load unit.
// Assumes: Register file lives here; memory in ld_mem_model.
// Notes: Seeded random loads plus hand-picked corners.
`include "ld_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk;
  logic sys_rst, instr_valid, busy, done, rf_ren, rf_wen, rf_user, psr_wen;
  logic mem_req, mem_byte, mem_trans, mem_rvalid, reg_wr, reg_rd;
  logic [1:0] cpu_mode;
  logic [3:0] cond_flags, rf_raddr, rf_waddr, reg_addr, bn, rd;
  logic [31:0] instr_word, instr_pc, rf_rdata, rf_wdata, psr_wdata, mem_addr;
  logic [31:0] mem_rdata, reg_wdata, reg_rdata, pc;
  logic [31:0] rf [16];
  logic [36:0] ew_q[$], gw_q[$], pe_q[$], gp_q[$];
  logic [11:0] off;
  logic [4:0] ctl;
  int err_total, n_tests, trans, i;

  ld_load_unit ld_load_unit_i (.*);
  ld_mem_model ld_mem_model_i (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (rf_wen)
    begin
      rf[rf_waddr] <= rf_wdata;
      gw_q.push_back({rf_user, rf_waddr, rf_wdata});
    end
    if (psr_wen)
      gp_q.push_back({5'h0, psr_wdata});
    if (mem_req && mem_trans)
      trans++;
  end

  // The unit latches read data in the cycle its read pulse stands.
  // Outside a read the port shows the inverse so stale data never passes.
  always_comb
  begin
    rf_rdata = rf_ren ? rf[rf_raddr] : ~rf[rf_raddr];
  end

  function automatic logic [31:0] mword(input logic [31:0] a);
    return {~a[17:2], a[17:2]};
  endfunction

  function automatic logic [31:0] shf(input logic [31:0] v,
      input logic [1:0] t, input logic [4:0] c);
    case (t)
      2'h0: return v << c;
      2'h1: return v >> c;
      2'h2: return $signed(v) >>> c;
      default: return (v >> c) | (v << (32 - int'(c)));
    endcase
  endfunction

  task automatic cmp(input string nm, input logic [36:0] e,
      input logic [36:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic reg_acc(input logic wr, input logic [3:0] a,
      input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (!wr)
      cmp("reg", 37'(d), 37'(reg_rdata));
  endtask

  task automatic run(input logic [31:0] w, input logic [1:0] md,
      input logic en);
    int k;
    @(posedge core_clk);
    instr_word <= w;
    instr_pc <= pc;
    cpu_mode <= md;
    instr_valid <= 1'b1;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
    trans = 0;
    for (k = 0; k < 200 && done !== 1'b1; k++)
    begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
    cmp("done", 37'(en), 37'(k < 200));
    cmp("nwr", 37'(ew_q.size()), 37'(gw_q.size()));
    foreach (ew_q[j]) cmp("wr", ew_q[j], gw_q[j]);
    cmp("npsr", 37'(pe_q.size()), 37'(gp_q.size()));
    foreach (pe_q[j]) cmp("psr", pe_q[j], gp_q[j]);
    ew_q = {};
    gw_q = {};
    pe_q = {};
    gp_q = {};
  endtask

  task automatic sld(input logic [3:0] c, input logic [4:0] f,
      input logic [3:0] b_n, input logic [3:0] d_n, input logic [11:0] o12,
      input logic [1:0] md, input logic ex);
    logic [31:0] b, o, ea, a, v;
    if (b_n != 4'hf)
      rf[b_n] = $urandom & 32'h00fffffc;
    b = (b_n == 4'hf) ? ((pc + `LD_PC_AHEAD) & `LD_PC_MASK) : rf[b_n];
    o = f[4] ? shf(rf[o12[3:0]], o12[6:5], o12[11:7]) : {20'h0, o12};
    ea = f[2] ? b + o : b - o;
    a = f[3] ? ea : b;
    v = mword(a);
    if (f[1])
      v = (v >> {a[1:0], 3'h0}) & 32'hff;
    if (ex)
    begin
      ew_q.push_back({1'b0, d_n, v});
      if ((f[0] || !f[3]) && b_n != d_n)
        ew_q.push_back({1'b0, b_n, ea});
    end
    run({c, 2'h1, f, 1'b1, b_n, d_n, o12}, md, 1'b1);
    cmp("trans", 37'(ex && md == 2'h3 && !f[3] && f[0]), 37'(trans != 0));
  endtask

  task automatic bld(input logic [3:0] f, input logic [3:0] b_n,
      input logic [15:0] l, input logic [1:0] md);
    logic [31:0] b, a, v;
    logic u;
    int n;
    rf[b_n] = $urandom & 32'h00fffffc;
    b = rf[b_n];
    n = $countones(l);
    a = f[2] ? b : b - 32'(4 * n);
    if (f[3] == f[2])
      a = a + 32'h4;
    u = f[1] && md != 2'h0 && !l[15];
    for (int r = 0; r < 16; r++)
      if (l[r])
      begin
        v = mword(a);
        if (r == 15 && f[1] && md != 2'h0)
          pe_q.push_back({5'h0, v & `LD_PSR_MASK});
        if (r == 15)
          v = (v - `LD_PC_RESTORE_ADJ) & `LD_PC_MASK;
        ew_q.push_back({u, 4'(r), v});
        a = a + 32'h4;
      end
    if (f[0] && !l[b_n])
      ew_q.push_back({1'b0, b_n, f[2] ? b + 32'(4 * n) : b - 32'(4 * n)});
    run({4'he, 3'h4, f, 1'b1, b_n, l}, md, 1'b1);
  endtask

  initial
  begin
    #200000;
    err_total++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'h90118be9));
    sys_rst = 1'b1;
    {instr_valid, reg_wr, reg_rd, cpu_mode, cond_flags, reg_addr} = '0;
    {instr_word, instr_pc, reg_wdata, pc} = '0;
    foreach (rf[k]) rf[k] = $urandom;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    reg_acc(1'b0, 4'h0, 32'h1);
    reg_acc(1'b0, 4'h1, 32'h0);
    reg_acc(1'b0, 4'h9, 32'h0);
    reg_acc(1'b1, 4'h0, 32'h0);
    run(32'he5901000, 2'h0, 1'b0);
    reg_acc(1'b1, 4'h0, 32'h1);
    sld(4'hf, 5'h0c, 4'h1, 4'h2, 12'h4, 2'h0, 1'b0);
    reg_acc(1'b0, 4'h1, 32'h2);
    sld(4'h0, 5'h0c, 4'h1, 4'h2, 12'h4, 2'h0, 1'b0);
    cond_flags <= 4'h4;
    sld(4'h0, 5'h0c, 4'h1, 4'h2, 12'h4, 2'h0, 1'b1);
    pc = $urandom & 32'h00fffffc;
    sld(4'he, 5'h0c, 4'hf, 4'h3, 12'h20, 2'h0, 1'b1);
    sld(4'he, 5'h05, 4'h4, 4'h5, 12'h8, 2'h3, 1'b1);
    for (i = 0; i < 16; i++)
    begin
      bn = 4'($urandom % 15);
      rd = 4'((bn + 1 + $urandom % 14) % 15);
      ctl = 5'($urandom);
      off = 12'($urandom);
      if (ctl[4])
      begin
        ctl[1] = 1'b1;
        off[11:7] = 5'(1 + $urandom % 31);
        off[4] = 1'b0;
        off[3:0] = off[3:0] % 4'hf;
      end
      else if (!ctl[1])
        off[1:0] = 2'h0;
      sld(4'he, ctl, bn, rd, off, 2'($urandom), 1'b1);
    end
    bld(4'h5, 4'h2, 16'h0, 2'h0);
    bld(4'he, 4'hd, 16'hffff, 2'h3);
    for (i = 0; i < 16; i++)
    begin
      bn = 4'($urandom % 15);
      ctl = 5'($urandom);
      ctl[3:2] = 2'(i);
      if (ctl[1])
        ctl[0] = 1'b0;
      bld(ctl[3:0], bn, 16'($urandom) & ~(16'h1 << bn), 2'($urandom));
    end
    reg_acc(1'b0, 4'h1, 32'h4);
    complete_run();
  end
endmodule
`default_nettype wire
